// ---- logic/pdg_pkg.sv ----
// Package of constants and types for the PWM period and duty generator
package pdg_pkg;
  localparam int DATA_W = 16;
  localparam int DIV_W = 3;
  // Prescale counter, wide enough for the slowest ratio of divide-by-128
  localparam int DIV_CNT_W = 7;
  // Control bit positions in the control words
  localparam int MODULE_ENABLE_BIT = 15;
  localparam int IMMEDIATE_PERIOD_UPDATE_BIT = 10;
  localparam int INDEPENDENT_TIMEBASE_SEL_BIT = 9;
  localparam int SHARED_DUTY_SELECT_BIT = 8;
  localparam int IMMEDIATE_DUTY_UPDATE_BIT = 0;
  // Duty clamp limits, in counts
  localparam logic [15:0] DUTY_MIN = 16'h0008;
  localparam logic [15:0] DUTY_MARGIN = 16'h0008;
  // Reset values
  localparam logic [15:0] PERIOD_RST = 16'hffff;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [6:0] DIV_RST = 7'h00;
  // Time per count at the fastest prescale, in picoseconds
  localparam int COUNT_TIME_PS = 1040;

  // Per-generator configuration carried as one group
  typedef struct packed {
    logic independentTimebaseSel;
    logic sharedDutySelect;
    logic immediateDutyUpdate;
    logic trueIndependent;
    logic useSecondaryMaster;
  } pdg_gen_cfg_t;

  // Duty values from software for one generator
  typedef struct packed {
    logic [15:0] primaryDuty;
    logic [15:0] secondaryDuty;
  } pdg_duty_pair_t;
endpackage : pdg_pkg

// ---- logic/pdg_pwm_period_duty_generator.sv ----
// One PWM generator with its master time bases, prescalers, shadows and duty clamps
// Behaviour
// - Period from master or local values
// - Select 0 keeps local counters on master
// - Select 1 lets local counters run free
// - Primary period both outputs unless true independent
// - Master period registers are 16-bit counts
// - Local period registers are 16-bit counts
// - Period writes accepted any time, running
// - One count per prescaled clock tick
// - Three-bit divider select, value 1 divides two
// - Enable bit 15 starts; clear stops, zeros
// - Bit 10 loads master period immediately
// - All duty registers are 16-bit compares
// - Bit 0 immediate duty, else next cycle
// - Bit 8 picks shared or own duty
// - Shared duty read by all at once; with bit 0 clear each output loads it at its own wrap
// - Independent, own duty: primary drives high
// - Independent, own duty: secondary drives low
// - Duty below 8 gives no pulse unless an upper clamp applies
// - Duty above period minus 8 stays on
// - Duty at or above period full on
// - Output on while count at or below duty
// - Counter wraps to zero at period
`timescale 1ns/100ps
`default_nettype none
module pdg_pwm_period_duty_generator #(
  parameter int DW = pdg_pkg::DATA_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [15:0] primaryMasterControl,
  input wire logic [15:0] secondaryMasterControl,
  input wire logic [2:0] primaryClockDividerSel,
  input wire logic [2:0] secondaryClockDividerSel,
  input wire logic [DW-1:0] primaryMasterPeriod,
  input wire logic [DW-1:0] secondaryMasterPeriod,
  input wire logic [DW-1:0] localPrimaryPeriod,
  input wire logic [DW-1:0] localSecondaryPeriod,
  input wire logic [15:0] generatorControl,
  input wire logic trueIndependent,
  input wire logic useSecondaryMaster,
  input wire logic [DW-1:0] masterDuty,
  input wire pdg_pkg::pdg_duty_pair_t dutyIn,
  output logic highOutput,
  output logic lowOutput,
  output logic [DW-1:0] primaryMasterTimer,
  output logic [DW-1:0] secondaryMasterTimer
);
  // Period in picoseconds of one count at full rate, kept for reference and not used by any check
  localparam int COUNT_PS = pdg_pkg::COUNT_TIME_PS;

  pdg_pkg::pdg_gen_cfg_t cfg;
  logic enable;
  logic [pdg_pkg::DIV_CNT_W-1:0] pDivCnt_reg, sDivCnt_reg;
  logic pTick, sTick;
  logic [DW-1:0] pShadow_reg, sShadow_reg;
  logic [DW-1:0] pTmr_reg, sTmr_reg;
  logic pWrap, sWrap;
  logic [DW-1:0] selTmr, selPer;
  logic selTick, selWrap;
  logic [DW-1:0] locPTmr_reg, locSTmr_reg;
  logic [DW-1:0] locPPer, locSPer;
  logic [DW-1:0] hiTmr, loTmr, hiPer, loPer;
  logic hiTick, loTick, hiWrap, loWrap;
  logic [DW-1:0] hiDutyAct_reg, loDutyAct_reg;
  logic [DW-1:0] hiDutyReq, loDutyReq;

  assign enable = primaryMasterControl[pdg_pkg::MODULE_ENABLE_BIT];
  assign cfg.independentTimebaseSel = generatorControl[pdg_pkg::INDEPENDENT_TIMEBASE_SEL_BIT];
  assign cfg.sharedDutySelect = generatorControl[pdg_pkg::SHARED_DUTY_SELECT_BIT];
  assign cfg.immediateDutyUpdate = generatorControl[pdg_pkg::IMMEDIATE_DUTY_UPDATE_BIT];
  assign cfg.trueIndependent = trueIndependent;
  assign cfg.useSecondaryMaster = useSecondaryMaster;

  // Tick when the divider count reaches 2^sel - 1; select 0 ticks every clock.
  // A count left above a newly lowered limit ticks at once instead of wrapping round.
  function automatic logic divTick(input logic [pdg_pkg::DIV_CNT_W-1:0] cnt,
                                   input logic [2:0] sel);
    logic [7:0] lim;
    lim = (8'h01 << sel) - 8'h01;
    divTick = ({1'b0, cnt} >= lim);
  endfunction : divTick

  // Edge-aligned compare with the documented clamps at both ends
  function automatic logic dutyOut(input logic [DW-1:0] tmr, input logic [DW-1:0] duty,
                                   input logic [DW-1:0] per);
    if (duty >= per) begin
      dutyOut = 1'b1;
    end else if (per >= pdg_pkg::DUTY_MARGIN && duty > per - pdg_pkg::DUTY_MARGIN) begin
      dutyOut = 1'b1;
    end else if (duty < pdg_pkg::DUTY_MIN) begin
      dutyOut = 1'b0;
    end else begin
      dutyOut = (tmr <= duty);
    end
  endfunction : dutyOut

  // Prescalers; a count cleared at each tick so a ratio of 2^sel is kept (1 gives divide-by-2)
  always_ff @(posedge clk) begin
    if (!nrst || !enable) begin
      pDivCnt_reg <= pdg_pkg::DIV_RST;
      sDivCnt_reg <= pdg_pkg::DIV_RST;
    end else begin
      pDivCnt_reg <= pTick ? pdg_pkg::DIV_RST : pDivCnt_reg + 7'h01;
      sDivCnt_reg <= sTick ? pdg_pkg::DIV_RST : sDivCnt_reg + 7'h01;
    end
  end
  assign pTick = enable && divTick(pDivCnt_reg, primaryClockDividerSel);
  assign sTick = enable && divTick(sDivCnt_reg, secondaryClockDividerSel);

  // Master period shadows; immediate mode tracks writes, else load at wrap
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pShadow_reg <= pdg_pkg::PERIOD_RST;
      sShadow_reg <= pdg_pkg::PERIOD_RST;
    end else begin
      if (primaryMasterControl[pdg_pkg::IMMEDIATE_PERIOD_UPDATE_BIT] || pWrap || !enable) begin
        pShadow_reg <= primaryMasterPeriod;
      end
      if (secondaryMasterControl[pdg_pkg::IMMEDIATE_PERIOD_UPDATE_BIT] || sWrap || !enable) begin
        sShadow_reg <= secondaryMasterPeriod;
      end
    end
  end

  assign pWrap = pTick && (pTmr_reg >= pShadow_reg);
  assign sWrap = sTick && (sTmr_reg >= sShadow_reg);

  // Master timers; cleared whenever the module is disabled
  always_ff @(posedge clk) begin
    if (!nrst || !enable) begin
      pTmr_reg <= pdg_pkg::COUNT_RST;
      sTmr_reg <= pdg_pkg::COUNT_RST;
    end else begin
      if (pTick) begin
        pTmr_reg <= pWrap ? pdg_pkg::COUNT_RST : pTmr_reg + 16'h0001;
      end
      if (sTick) begin
        sTmr_reg <= sWrap ? pdg_pkg::COUNT_RST : sTmr_reg + 16'h0001;
      end
    end
  end
  assign primaryMasterTimer = pTmr_reg;
  assign secondaryMasterTimer = sTmr_reg;

  assign selTmr = cfg.useSecondaryMaster ? sTmr_reg : pTmr_reg;
  assign selPer = cfg.useSecondaryMaster ? sShadow_reg : pShadow_reg;
  assign selTick = cfg.useSecondaryMaster ? sTick : pTick;
  assign selWrap = cfg.useSecondaryMaster ? sWrap : pWrap;

  // Local periods: primary covers both outputs unless true independent
  assign locPPer = localPrimaryPeriod;
  assign locSPer = cfg.trueIndependent ? localSecondaryPeriod : localPrimaryPeriod;

  // Local timers count on the selected master tick; written periods used live
  always_ff @(posedge clk) begin
    if (!nrst) begin
      locPTmr_reg <= pdg_pkg::COUNT_RST;
      locSTmr_reg <= pdg_pkg::COUNT_RST;
    end else if (!cfg.independentTimebaseSel) begin
      locPTmr_reg <= selTmr;
      locSTmr_reg <= selTmr;
    end else if (selTick) begin
      locPTmr_reg <= (locPTmr_reg >= locPPer) ? pdg_pkg::COUNT_RST
                                              : locPTmr_reg + 16'h0001;
      locSTmr_reg <= (locSTmr_reg >= locSPer) ? pdg_pkg::COUNT_RST
                                              : locSTmr_reg + 16'h0001;
    end
  end

  // Period and timer routed per output; lag of one cycle on synced local copy avoided
  assign hiTmr = cfg.independentTimebaseSel ? locPTmr_reg : selTmr;
  assign loTmr = cfg.independentTimebaseSel ? locSTmr_reg : selTmr;
  assign hiPer = cfg.independentTimebaseSel ? locPPer : selPer;
  assign loPer = cfg.independentTimebaseSel ? locSPer : selPer;
  // Local timers share the selected master prescaler tick
  assign hiTick = selTick;
  assign loTick = selTick;
  assign hiWrap = cfg.independentTimebaseSel ? (hiTick && locPTmr_reg >= locPPer) : selWrap;
  assign loWrap = cfg.independentTimebaseSel ? (loTick && locSTmr_reg >= locSPer) : selWrap;

  // Duty source: shared master duty feeds every generator that selects it
  assign hiDutyReq = cfg.sharedDutySelect ? masterDuty
                                          : dutyIn.primaryDuty;
  assign loDutyReq = cfg.sharedDutySelect ? masterDuty : dutyIn.secondaryDuty;

  // Active duty: immediate, or loaded at cycle start so a cycle never splits
  always_ff @(posedge clk) begin
    if (!nrst) begin
      hiDutyAct_reg <= pdg_pkg::COUNT_RST;
      loDutyAct_reg <= pdg_pkg::COUNT_RST;
    end else begin
      if (cfg.immediateDutyUpdate || hiWrap || !enable) begin
        hiDutyAct_reg <= hiDutyReq;
      end
      if (cfg.immediateDutyUpdate || loWrap || !enable) begin
        loDutyAct_reg <= loDutyReq;
      end
    end
  end

  // Registered outputs; held low while the module is off
  always_ff @(posedge clk) begin
    if (!nrst || !enable) begin
      highOutput <= 1'b0;
      lowOutput <= 1'b0;
    end else begin
      highOutput <= dutyOut(hiTmr, hiDutyAct_reg, hiPer);
      lowOutput <= dutyOut(loTmr, loDutyAct_reg, loPer);
    end
  end

  // Helper for checks: previous enable
  logic enPrev_reg;
  always_ff @(posedge clk) begin
    enPrev_reg <= nrst ? enable : 1'b0;
  end

  property p_disable_clears;
    @(posedge clk) disable iff (!nrst) !enable |=> (pTmr_reg == 16'h0000 && sTmr_reg == 16'h0000);
  endproperty
  a_disable_clears: assert property (p_disable_clears)
    else $error("timers not cleared");

  // A fresh enable always starts the master count from zero
  property p_enable_start;
    @(posedge clk) disable iff (!nrst) (enable && !enPrev_reg) |-> pTmr_reg == 16'h0000;
  endproperty
  a_enable_start: assert property (p_enable_start)
    else $error("timer not zero at enable");

  property p_wrap_zero;
    @(posedge clk) disable iff (!nrst) (enable && pWrap) |=> pTmr_reg == 16'h0000;
  endproperty
  a_wrap_zero: assert property (p_wrap_zero)
    else $error("master timer did not wrap");

  property p_sec_wrap_zero;
    @(posedge clk) disable iff (!nrst) (enable && sWrap) |=> sTmr_reg == 16'h0000;
  endproperty
  a_sec_wrap_zero: assert property (p_sec_wrap_zero)
    else $error("secondary timer did not wrap");

  property p_count_step;
    @(posedge clk) disable iff (!nrst)
      (enable && pTick && !pWrap) |=> pTmr_reg == $past(pTmr_reg) + 16'h0001;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("master timer step wrong");

  property p_hold_no_tick;
    @(posedge clk) disable iff (!nrst) (enable && !pTick) ##1 enable |-> $stable(pTmr_reg);
  endproperty
  a_hold_no_tick: assert property (p_hold_no_tick)
    else $error("timer moved without tick");

  property p_div2;
    @(posedge clk) disable iff (!nrst)
      (enable && primaryClockDividerSel == 3'h1 && pTick)
      ##1 (enable && primaryClockDividerSel == 3'h1)
      |-> !pTick ##1 (pTick || !enable || primaryClockDividerSel != 3'h1);
  endproperty
  a_div2: assert property (p_div2)
    else $error("divide by two broken");

  property p_immediate_period;
    @(posedge clk) disable iff (!nrst)
      primaryMasterControl[pdg_pkg::IMMEDIATE_PERIOD_UPDATE_BIT]
      |=> pShadow_reg == $past(primaryMasterPeriod);
  endproperty
  a_immediate_period: assert property (p_immediate_period)
    else $error("period not immediate");

  property p_sec_immediate_period;
    @(posedge clk) disable iff (!nrst)
      secondaryMasterControl[pdg_pkg::IMMEDIATE_PERIOD_UPDATE_BIT]
      |=> sShadow_reg == $past(secondaryMasterPeriod);
  endproperty
  a_sec_immediate_period: assert property (p_sec_immediate_period)
    else $error("secondary period not immediate");

  property p_sync_local;
    @(posedge clk) disable iff (!nrst)
      !cfg.independentTimebaseSel |=> locPTmr_reg == $past(selTmr);
  endproperty
  a_sync_local: assert property (p_sync_local)
    else $error("local timer not synced");

  property p_zero_duty;
    @(posedge clk) disable iff (!nrst)
      (hiDutyAct_reg < pdg_pkg::DUTY_MIN && hiPer > 16'h0010) |=> !highOutput;
  endproperty
  a_zero_duty: assert property (p_zero_duty)
    else $error("small duty pulsed");

  property p_full_duty;
    @(posedge clk) disable iff (!nrst) (enable && hiDutyAct_reg >= hiPer) |=> highOutput;
  endproperty
  a_full_duty: assert property (p_full_duty)
    else $error("full duty not held");

  property p_dual_duty_hold;
    @(posedge clk) disable iff (!nrst)
      (!cfg.immediateDutyUpdate && !hiWrap && enable) |=> $stable(hiDutyAct_reg);
  endproperty
  a_dual_duty_hold: assert property (p_dual_duty_hold)
    else $error("duty changed mid cycle");

  c_wrap: cover property (@(posedge clk) disable iff (!nrst) enable && pWrap);
  c_pulse: cover property (@(posedge clk) disable iff (!nrst) highOutput ##1 !highOutput);
  c_indep: cover property (@(posedge clk) disable iff (!nrst) cfg.independentTimebaseSel && loWrap);
  c_shared: cover property (@(posedge clk) disable iff (!nrst) cfg.sharedDutySelect && lowOutput);
endmodule : pdg_pwm_period_duty_generator
`default_nettype wire

// ---- testbench/pdg_power_stage.sv ----
// Power stage model that totals the on-cycles of both gate drives
`timescale 1ns/100ps
`default_nettype none
module pdg_power_stage (
  input wire logic clk,
  input wire logic clear,
  input wire logic meas,
  input wire logic highGate,
  input wire logic lowGate,
  output logic [15:0] highCount,
  output logic [15:0] lowCount
);
  // On-time totals; an unknown gate level poisons the total so it cannot pass
  always_ff @(posedge clk) begin
    if (clear) begin
      highCount <= 16'h0000;
      lowCount <= 16'h0000;
    end else if (meas) begin
      highCount <= highCount + {15'h0000, highGate};
      lowCount <= lowCount + {15'h0000, lowGate};
    end
  end
endmodule : pdg_power_stage
`default_nettype wire

// ---- testbench/pdg_pwm_period_duty_generator_tb.sv ----
// Self-checking bench for the PWM period and duty generator
`timescale 1ns/100ps
`default_nettype none
module pdg_pwm_period_duty_generator_tb;
  logic clk, nrst, trueInd, useSec, clear, meas, hi, lo;
  logic [15:0] pCtl, sCtl, pPer, sPer, lpPer, lsPer, gCtl, mDuty, pTmr, sTmr, hiCnt, loCnt;
  logic [2:0] pDiv, sDiv;
  pdg_pkg::pdg_duty_pair_t duty;
  int n_fail, n_tests;

  pdg_pwm_period_duty_generator pdg_pwm_period_duty_generator_inst (.clk(clk), .nrst(nrst),
    .primaryMasterControl(pCtl), .secondaryMasterControl(sCtl),
    .primaryClockDividerSel(pDiv), .secondaryClockDividerSel(sDiv),
    .primaryMasterPeriod(pPer), .secondaryMasterPeriod(sPer), .localPrimaryPeriod(lpPer),
    .localSecondaryPeriod(lsPer), .generatorControl(gCtl), .trueIndependent(trueInd),
    .useSecondaryMaster(useSec), .masterDuty(mDuty), .dutyIn(duty), .highOutput(hi),
    .lowOutput(lo), .primaryMasterTimer(pTmr), .secondaryMasterTimer(sTmr));
  pdg_power_stage pdg_power_stage_inst (.clk(clk), .clear(clear), .meas(meas), .highGate(hi),
    .lowGate(lo), .highCount(hiCnt), .lowCount(loCnt));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude;
    $display("tests=%0d failures=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  // Load settings while disabled so shadows and duties take them directly, then run
  task automatic setup(input logic [15:0] per, input logic [15:0] dty, input logic [15:0] g);
    @(posedge clk) pCtl <= 16'h0000;
    pPer <= per;
    mDuty <= dty;
    gCtl <= g;
    repeat (3) @(posedge clk);
    pCtl <= 16'h8000;
    repeat (300) @(posedge clk);
  endtask : setup
  // Whole periods in the window make the on-count independent of phase
  task automatic meas_chk(input int n, input int eh, input int el);
    @(posedge clk) clear <= 1'b1;
    @(posedge clk) clear <= 1'b0;
    meas <= 1'b1;
    repeat (n) @(posedge clk);
    meas <= 1'b0;
    @(negedge clk);
    check(hiCnt, 16'(eh));
    check(loCnt, 16'(el));
  endtask : meas_chk
  task automatic wait_tmr(input logic [15:0] v);
    int i;
    i = 0;
    @(negedge clk);
    while (pTmr !== v && i < 600) begin
      @(negedge clk);
      i++;
    end
    check(pTmr, v);
  endtask : wait_tmr
  task automatic t_master;
    for (int s = 0; s < 2; s++) begin
      @(posedge clk) useSec <= s[0];
      sPer <= 16'h0018;
      // Secondary pass runs at half rate with immediate period updates
      sDiv <= 3'(s);
      sCtl <= s ? 16'h0400 : 16'h0000;
      setup(16'h0020, 16'h0010, 16'h0100);
      meas_chk(s ? 200 : 132, s ? 136 : 68, s ? 136 : 68);
    end
    @(posedge clk) useSec <= 1'b0;
  endtask : t_master
  task automatic t_clamp;
    logic [15:0] d[6] = '{16'h0007, 16'h0008, 16'h0018, 16'h0019, 16'h0020, 16'hffff};
    int e[6] = '{0, 9, 25, 33, 33, 33};
    for (int k = 0; k < 6; k++) begin
      setup(16'h0020, d[k], 16'h0100);
      meas_chk(2 * 33, 2 * e[k], 2 * e[k]);
    end
  endtask : t_clamp
  // Common multiple 1225 of both local periods keeps each window whole
  task automatic t_indep;
    for (int ti = 0; ti < 2; ti++) begin
      @(posedge clk) trueInd <= ti[0];
      setup(16'h0020, 16'h0004, 16'h0200);
      meas_chk(1225, 25 * 17, ti ? 49 * 13 : 25 * 13);
    end
    @(posedge clk) trueInd <= 1'b0;
  endtask : t_indep
  task automatic t_prescale;
    @(posedge clk) pDiv <= 3'h1;
    setup(16'h0020, 16'h0010, 16'h0100);
    meas_chk(2 * 66, 2 * 34, 2 * 34);
    @(posedge clk) pDiv <= 3'h0;
  endtask : t_prescale
  task automatic t_enable;
    setup(16'h0020, 16'h0010, 16'h0100);
    wait_tmr(16'h0005);
    @(negedge clk) check(pTmr, 16'h0006);
    @(posedge clk) pCtl <= 16'h0000;
    repeat (6) @(posedge clk);
    @(negedge clk) check(pTmr, 16'h0000);
    check(sTmr, 16'h0000);
    check({15'h0000, hi}, 16'h0000);
  endtask : t_enable
  task automatic t_update;
    setup(16'h0100, 16'h0010, 16'h0100);
    wait_tmr(16'h0004);
    @(posedge clk) pPer <= 16'h0010;
    repeat (48) @(posedge clk);
    @(negedge clk) check({15'h0000, pTmr > 16'h0010}, 16'h0001);
    wait_tmr(16'h0002);
    @(posedge clk) pPer <= 16'h0100;
    pCtl <= 16'h8400;
    repeat (32) @(posedge clk);
    @(negedge clk) check({15'h0000, pTmr > 16'h0010}, 16'h0001);
    setup(16'h0040, 16'h0030, 16'h0100);
    wait_tmr(16'h0002);
    @(posedge clk) mDuty <= 16'h0008;
    wait_tmr(16'h0020);
    @(negedge clk) check({15'h0000, hi}, 16'h0001);
    wait_tmr(16'h0002);
    @(posedge clk) gCtl <= 16'h0101;
    mDuty <= 16'h0030;
    wait_tmr(16'h0020);
    @(negedge clk) check({15'h0000, hi}, 16'h0001);
  endtask : t_update

  // Free-running clock at 4 ns
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Watchdog sized well past the expected run of some 8000 cycles
  initial begin
    #200000;
    n_fail++;
    conclude();
  end
  // Main sequence
  initial begin
    n_fail = 0;
    n_tests = 0;
    nrst = 1'b0;
    {clear, meas, trueInd, useSec} = 4'h0;
    {pCtl, sCtl, gCtl, mDuty} = 64'h0;
    {pPer, sPer, lpPer, lsPer} = {16'h0020, 16'h0018, 16'h0030, 16'h0018};
    {pDiv, sDiv} = 6'h00;
    duty = '{primaryDuty: 16'h0010, secondaryDuty: 16'h000c};
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_master();
    t_clamp();
    t_indep();
    t_prescale();
    t_enable();
    t_update();
    conclude();
  end
endmodule : pdg_pwm_period_duty_generator_tb
`default_nettype wire
